//--- dv/pcr_config_regs_checker.sv
// port assertions for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module pcr_config_regs_checker (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_addr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic i_rx_sym_valid,
	input wire logic i_rx_sym_idle,
	input wire logic i_rx_sym_error,
	input wire logic i_rx_active,
	input wire logic i_rx_byte_valid,
	input wire logic i_test_start,
	input wire logic o_descr_unlocked,
	input wire logic o_rem_rcvr_ok,
	input wire logic o_rx_jabber,
	input wire logic o_tp_active,
	input wire logic o_tp_symbol_pos,
	input wire logic o_rx_out_valid,
	input wire logic o_sfd_found
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata outside read");
	AST_ILV_RO: assert property ($past(i_rd) && $past(i_addr) == 12'h489 |-> o_rdata[15:3] == 13'h0000)
		else $error("ro bits set");
	AST_RXF_RO: assert property ($past(i_rd) && $past(i_addr) == 12'h4A0 |-> !o_rdata[1]) else $error("bit1 set");
	AST_BYTE_LAT: assert property (i_rx_byte_valid |=> o_rx_out_valid) else $error("byte lost");
	AST_SFD_AFTER: assert property (o_sfd_found |-> $past(o_rx_out_valid)) else $error("sfd no byte");
	AST_TP_START: assert property (i_test_start && !o_tp_active |=> o_tp_active && o_tp_symbol_pos)
		else $error("burst start");
	AST_TP_ALT: assert property (o_tp_active && $past(o_tp_active) |-> o_tp_symbol_pos != $past(o_tp_symbol_pos))
		else $error("no toggle");
	AST_IDLE_LOCK: assert property (i_rx_sym_valid && i_rx_sym_idle |=> !o_descr_unlocked) else $error("idle");
	AST_GOOD_OK: assert property (i_rx_sym_valid && !i_rx_sym_error |=> o_rem_rcvr_ok) else $error("ok");
	AST_JAB_DROP: assert property (!i_rx_active |=> !o_rx_jabber) else $error("jabber stuck");
	cover property (o_rx_jabber);
	cover property (o_descr_unlocked);
	cover property (o_sfd_found);
endmodule : pcr_config_regs_checker
bind pcr_config_regs pcr_config_regs_checker i_chk (.i_ref_clk, .i_sys_rst, .i_addr, .i_rd, .o_rdata, .i_rx_sym_valid,
	.i_rx_sym_idle, .i_rx_sym_error, .i_rx_active, .i_rx_byte_valid, .i_test_start, .o_descr_unlocked,
	.o_rem_rcvr_ok, .o_rx_jabber, .o_tp_active, .o_tp_symbol_pos, .o_rx_out_valid, .o_sfd_found);
`default_nettype wire

//--- dv/pcr_rx_src.sv
// received byte source standing in for the line side
`timescale 1ns/1ps
`default_nettype none
module pcr_rx_src (
	input wire logic i_ref_clk,
	output logic o_valid,
	output logic [7:0] o_byte
);
	initial begin
		o_valid = 1'b0;
		o_byte = 8'h00;
	end
	// idle data is the inverse of the last byte, so a stale value never passes
	task automatic send(input logic [7:0] b);
		@(posedge i_ref_clk);
		o_valid <= 1'b1;
		o_byte <= b;
		@(posedge i_ref_clk);
		o_valid <= 1'b0;
		o_byte <= ~b;
	endtask : send
endmodule : pcr_rx_src
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pcr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rdd = 1'b0;
	logic sv = 1'b0, si = 1'b0, se = 1'b0, seen = 1'b0, act = 1'b0, ts = 1'b0, bv;
	logic [11:0] addr = 12'h000;
	logic [15:0] wd = 16'h0000, rnd, rdata, q[$];
	logic [7:0] bb, ob, bq[$];
	logic unl, ok, den, txi, jab, tpa, tpp, ov, sfd, ext;
	logic [11:0] ra[5] = '{12'h486, 12'h489, 12'h496, 12'h497, 12'h4A0};
	logic [15:0] rv[5] = '{16'h0A05, 16'h0001, 16'h044C, 16'h01C0, 16'h1000};
	logic [15:0] rm[5] = '{16'hFF1F, 16'h0007, 16'h07FF, 16'h03F0, 16'hFFFD};
	logic [3:0] il[4] = '{4'h8, 4'h4, 4'h7, 4'h3};
	logic [5:0] tl[2] = '{6'h00, 6'h3F};
	int n_errors = 0, checked = 0, n;
	always #20 clk = ~clk;
	pcr_rx_src i_src (.i_ref_clk(clk), .o_valid(bv), .o_byte(bb));
	pcr_config_regs i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_rx_sym_valid(sv), .i_rx_sym_idle(si), .i_rx_sym_error(se), .i_rx_ilv_seen(seen),
		.i_rx_active(act), .i_tick_us_ext_unused(1'b0), .i_rx_byte_valid(bv), .i_rx_byte(bb), .i_test_start(ts),
		.o_descr_unlocked(unl), .o_rem_rcvr_ok(ok), .o_ilv_detect_en(den), .o_tx_interleave(txi), .o_rx_jabber(jab),
		.o_tp_active(tpa), .o_tp_symbol_pos(tpp), .o_rx_out_valid(ov), .o_rx_out_byte(ob), .o_sfd_found(sfd),
		.o_ext_rx_en(ext));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// strobes stay up across back-to-back calls; idle drops them
	task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		if (!w) q.push_back(d);
	endtask : bus
	task automatic idle;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : idle
	task automatic sym(input logic i, input logic e);
		@(posedge clk);
		sv <= 1'b1;
		si <= i;
		se <= e;
		@(posedge clk);
		sv <= 1'b0;
		@(negedge clk);
	endtask : sym
	function automatic logic [7:0] reord(input logic [1:0] o, input logic [7:0] b);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = b[7 - i];
		case (o)
			2'h0: return b;
			2'h1: return r;
			2'h2: return {b[3:0], b[7:4]};
			default: return {r[3:0], r[7:4]};
		endcase
	endfunction : reord
	// ****************************************
	// result watcher
	// ****************************************
	always @(posedge clk) rdd <= rd;
	always @(negedge clk) begin
		if (rdd) chk(rdata, q.pop_front());
		if (ov === 1'b1) chk({8'h00, ob}, {8'h00, bq.pop_front()});
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'hC8C0BFED));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({den, ok, unl, jab, tpa, ext}, 6'b110000);
		for (int i = 0; i < 5; i++) bus(1'b0, ra[i], rv[i]);
		for (int i = 0; i < 5; i++) begin
			rnd = $urandom;
			bus(1'b1, ra[i], rnd);
			bus(1'b0, ra[i], rnd & rm[i]);
		end
		bus(1'b1, 12'h400, 16'hFFFF);
		bus(1'b0, 12'h400, 16'h0000);
		bus(1'b1, 12'h486, 16'h0302);
		idle();
		for (int i = 1; i <= 4; i++) begin
			sym(1'b0, 1'b1);
			chk({unl, ok}, {i >= 3, i < 2});
		end
		sym(1'b1, 1'b0);
		chk({unl, ok}, 2'b01);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 12'h489, {13'h0000, il[i][3:1]});
			seen <= il[i][0];
			idle();
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({den, txi}, {il[i][1], il[i][3] | (il[i][2] & il[i][1] & il[i][0])});
		end
		bus(1'b1, 12'h496, 16'h0002);
		idle();
		act <= 1'b1;
		n = 0;
		while (jab !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(n >= 49 && n <= 53, 1'b1);
		act <= 1'b0;
		repeat (2) @(negedge clk);
		chk(jab, 1'b0);
		foreach (tl[t]) begin
			bus(1'b1, 12'h497, {6'h00, tl[t], 4'h0});
			idle();
			ts <= 1'b1;
			@(posedge clk);
			ts <= 1'b0;
			n = 0;
			repeat (140) begin
				@(negedge clk);
				n += (tpa === 1'b1);
			end
			chk(16'(n), 16'(2 + 2 * tl[t]));
		end
		for (int o = 0; o < 4; o++) begin
			bus(1'b1, 12'h4A0, {o[1:0], 14'h0080});
			idle();
			rnd = $urandom;
			bq.push_back(reord(o[1:0], rnd[7:0]));
			i_src.send(rnd[7:0]);
		end
		chk(ext, 1'b1);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 12'h4A0, {2'h0, s[1], 13'h0000});
			idle();
			bq.push_back(s[0] ? 8'hD5 : 8'h5D);
			i_src.send(s[0] ? 8'hD5 : 8'h5D);
			@(posedge clk);
			@(negedge clk);
			chk(sfd, s[0] ^ s[1]);
		end
		// mid-run reset must bring the control outputs and the receive framing and interleave registers back to their reset values
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({den, ok, unl, jab, tpa, ext}, 6'b110000);
		bus(1'b0, 12'h4A0, 16'h1000);
		bus(1'b0, 12'h489, 16'h0001);
		idle();
		repeat (3) @(posedge clk);
		finish_test();
	end
endmodule : testbench
`default_nettype wire

//--- rtl/pcr_byte_order.sv
// reorders one received byte as the order field selects
`timescale 1ns/1ps
`default_nettype none
module pcr_byte_order (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire pcr_pkg::pcr_order_e i_order,
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	output logic o_valid,
	output logic [7:0] o_byte
);
	import pcr_pkg::*;
	logic [7:0] rev;
	logic [7:0] nibrev;
	logic [7:0] ord_nxt;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_rev
			assign rev[g] = i_byte[7 - g];
			assign nibrev[g] = i_byte[(g & 4) + 3 - (g & 3)];
		end
	endgenerate

	always_comb begin
		case (i_order)
			PCR_ORD_NATURAL: ord_nxt = i_byte;
			PCR_ORD_BITREV: ord_nxt = rev;
			PCR_ORD_NIBSWAP: ord_nxt = {i_byte[3:0], i_byte[7:4]};
			PCR_ORD_NIBREV: ord_nxt = nibrev;
			default: ord_nxt = i_byte;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_valid <= 1'b0;
			o_byte <= 8'h00;
		end else begin
			o_valid <= i_valid;
			o_byte <= ord_nxt;
		end
	end
endmodule : pcr_byte_order
`default_nettype wire

//--- rtl/pcr_config_regs.sv
// pcs and receive framing configuration registers with their controlled logic
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defines.svh"
module pcr_config_regs (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_rx_sym_valid,
	input wire logic i_rx_sym_idle,
	input wire logic i_rx_sym_error,
	input wire logic i_rx_ilv_seen,
	input wire logic i_rx_active,
	input wire logic i_tick_us_ext_unused,
	input wire logic i_rx_byte_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_test_start,
	output logic o_descr_unlocked,
	output logic o_rem_rcvr_ok,
	output logic o_ilv_detect_en,
	output logic o_tx_interleave,
	output logic o_rx_jabber,
	output logic o_tp_active,
	output logic o_tp_symbol_pos,
	output logic o_rx_out_valid,
	output logic [7:0] o_rx_out_byte,
	output logic o_sfd_found,
	output logic o_ext_rx_en
);
	import pcr_pkg::*;

	// ****************************************
	// register storage
	// ****************************************
	logic [15:0] thresh_r;
	logic [15:0] ilv_r;
	logic [15:0] jab_r;
	logic [15:0] test_r;
	logic [15:0] rxf_r;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			thresh_r <= `PCR_RST_THRESH;
			ilv_r <= `PCR_RST_ILV;
			jab_r <= `PCR_RST_JAB;
			test_r <= `PCR_RST_TEST;
			rxf_r <= `PCR_RST_RXF;
		end else if (i_wr) begin
			// masks keep read-only reserved bits at zero
			case (i_addr)
				`PCR_ADDR_THRESH: thresh_r <= i_wdata & `PCR_MASK_THRESH;
				`PCR_ADDR_ILV: ilv_r <= i_wdata & `PCR_MASK_ILV;
				`PCR_ADDR_JAB: jab_r <= i_wdata & `PCR_MASK_JAB;
				`PCR_ADDR_TEST: test_r <= i_wdata & `PCR_MASK_TEST;
				`PCR_ADDR_RXF: rxf_r <= i_wdata & `PCR_MASK_RXF;
				default: ;
			endcase
		end
	end

	// ****************************************
	// read port
	// ****************************************
	logic [15:0] rdata_nxt;
	always_comb begin
		case (i_addr)
			`PCR_ADDR_THRESH: rdata_nxt = thresh_r;
			`PCR_ADDR_ILV: rdata_nxt = ilv_r;
			`PCR_ADDR_JAB: rdata_nxt = jab_r;
			`PCR_ADDR_TEST: rdata_nxt = test_r;
			`PCR_ADDR_RXF: rdata_nxt = rxf_r;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// ****************************************
	// descrambler unlock
	// ****************************************
	logic [7:0] unlock_cnt_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			unlock_cnt_r <= 8'h00;
			o_descr_unlocked <= 1'b0;
		end else if (i_rx_sym_valid) begin
			if (i_rx_sym_idle) begin
				unlock_cnt_r <= 8'h00;
				o_descr_unlocked <= 1'b0;
			end else if (unlock_cnt_r + 8'h01 >= thresh_r[`PCR_UNLOCK_HI:`PCR_UNLOCK_LO]) begin
				o_descr_unlocked <= 1'b1;
			end else begin
				unlock_cnt_r <= unlock_cnt_r + 8'h01;
			end
		end
	end

	// ****************************************
	// remote receiver status
	// ****************************************
	logic [4:0] err_cnt_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			err_cnt_r <= 5'h00;
			o_rem_rcvr_ok <= 1'b1;
		end else if (i_rx_sym_valid) begin
			if (!i_rx_sym_error) begin
				err_cnt_r <= 5'h00;
				o_rem_rcvr_ok <= 1'b1;
			end else if (err_cnt_r + 5'h01 >= thresh_r[`PCR_REMERR_HI:`PCR_REMERR_LO]) begin
				o_rem_rcvr_ok <= 1'b0;
			end else begin
				err_cnt_r <= err_cnt_r + 5'h01;
			end
		end
	end

	// ****************************************
	// interleave control
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_ilv_detect_en <= 1'b1;
			o_tx_interleave <= 1'b0;
		end else begin
			o_ilv_detect_en <= ilv_r[`PCR_ILV_DETEN];
			// detection result only counts while detection is enabled
			o_tx_interleave <= ilv_r[`PCR_ILV_FORCE]
				| (ilv_r[`PCR_ILV_FOLLOW] & ilv_r[`PCR_ILV_DETEN] & i_rx_ilv_seen);
		end
	end

	// ****************************************
	// receive jabber timer
	// ****************************************
	logic [4:0] us_div_r;
	logic [10:0] jab_us_r;
	logic us_tick;
	assign us_tick = (us_div_r == 5'(`PCR_US_CYCLES - 1));

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_rx_active) begin
			us_div_r <= 5'h00;
		end else if (us_tick) begin
			us_div_r <= 5'h00;
		end else begin
			us_div_r <= us_div_r + 5'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_rx_active) begin
			jab_us_r <= 11'h000;
			o_rx_jabber <= 1'b0;
		end else if (us_tick) begin
			if (jab_us_r + 11'h001 >= jab_r[`PCR_JAB_HI:`PCR_JAB_LO]) begin
				o_rx_jabber <= 1'b1;
			end else begin
				jab_us_r <= jab_us_r + 11'h001;
			end
		end
	end

	// ****************************************
	// test pattern and byte order
	// ****************************************
	pcr_test_pattern u_tp (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_start(i_test_start),
		.i_len(test_r[`PCR_TP1_HI:`PCR_TP1_LO]),
		.o_active(o_tp_active),
		.o_symbol_pos(o_tp_symbol_pos)
	);

	pcr_byte_order u_ord (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_order(pcr_order_e'(rxf_r[`PCR_ORD_HI:`PCR_ORD_LO])),
		.i_valid(i_rx_byte_valid),
		.i_byte(i_rx_byte),
		.o_valid(o_rx_out_valid),
		.o_byte(o_rx_out_byte)
	);

	// ****************************************
	// delimiter search and extended features
	// ****************************************
	logic [7:0] sfd_pat;
	assign sfd_pat = rxf_r[`PCR_SFD_SEL] ? `PCR_SFD_ALT : `PCR_SFD_NORMAL;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_sfd_found <= 1'b0;
			o_ext_rx_en <= 1'b0;
		end else begin
			o_sfd_found <= o_rx_out_valid && (o_rx_out_byte == sfd_pat);
			// features downstream stay off until software sets this
			o_ext_rx_en <= rxf_r[`PCR_EXT_EN];
		end
	end
endmodule : pcr_config_regs
`default_nettype wire

//--- rtl/pcr_defines.svh
// constants for the pcs and receive framing configuration registers
//
// Operation
// - the descrambler is declared unlocked after a programmable count of non-idle symbols held in bits 15-8, reset 1010b.
// - remote receiver status goes low after a programmable count of error symbols held in bits 4-0, reset 101b.
// - the force-transmit-interleave bit 2 turns transmit interleave on unconditionally and resets to zero.
// - the transmit-interleave-follow bit 1 enables transmit interleave only when interleave is detected on receive.
// - bit 0 enables receive interleave detection and resets to one.
// - receive jabber is detected with a microsecond timeout taken from bits 10-0 of the jabber register.
// - test mode one sends alternating +1/-1 symbols, two plus twice the programmed count of them.
// - bits 15-14 reorder each received byte: natural, bit reversed, nibbles swapped, bits reversed per nibble.
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// ****************************************
// register addresses
// ****************************************
`define PCR_ADDR_THRESH 12'h486
`define PCR_ADDR_ILV 12'h489
`define PCR_ADDR_JAB 12'h496
`define PCR_ADDR_TEST 12'h497
`define PCR_ADDR_RXF 12'h4A0

// ****************************************
// writable masks and reset values
// ****************************************
`define PCR_MASK_THRESH 16'hFF1F
`define PCR_RST_THRESH 16'h0A05
`define PCR_MASK_ILV 16'h0007
`define PCR_RST_ILV 16'h0001
`define PCR_MASK_JAB 16'h07FF
`define PCR_RST_JAB 16'h044C
`define PCR_MASK_TEST 16'h03F0
`define PCR_RST_TEST 16'h01C0
`define PCR_MASK_RXF 16'hFFFD
`define PCR_RST_RXF 16'h1000

// ****************************************
// field positions
// ****************************************
`define PCR_UNLOCK_HI 15
`define PCR_UNLOCK_LO 8
`define PCR_REMERR_HI 4
`define PCR_REMERR_LO 0
`define PCR_ILV_FORCE 2
`define PCR_ILV_FOLLOW 1
`define PCR_ILV_DETEN 0
`define PCR_JAB_HI 10
`define PCR_JAB_LO 0
`define PCR_TP1_HI 9
`define PCR_TP1_LO 4
`define PCR_ORD_HI 15
`define PCR_ORD_LO 14
`define PCR_SFD_SEL 13
`define PCR_EXT_EN 7

// ****************************************
// codes and timing
// ****************************************
`define PCR_SFD_NORMAL 8'hD5
`define PCR_SFD_ALT 8'h5D
`define PCR_CLK_MHZ 25
`define PCR_US_CYCLES (`PCR_CLK_MHZ)

`endif

//--- rtl/pcr_pkg.sv
// types shared by the configuration register block
package pcr_pkg;
	typedef enum logic [1:0] {
		PCR_ORD_NATURAL,
		PCR_ORD_BITREV,
		PCR_ORD_NIBSWAP,
		PCR_ORD_NIBREV
	} pcr_order_e;
	typedef enum logic [1:0] {
		PCR_TP_IDLE,
		PCR_TP_SEND
	} pcr_tp_e;
endpackage : pcr_pkg

//--- rtl/pcr_test_pattern.sv
// test mode one burst of alternating symbols
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defines.svh"
module pcr_test_pattern (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_start,
	input wire logic [5:0] i_len,
	output logic o_active,
	output logic o_symbol_pos
);
	import pcr_pkg::*;
	pcr_tp_e state_r;
	logic [6:0] left_r;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r <= PCR_TP_IDLE;
			left_r <= 7'h00;
			o_active <= 1'b0;
			o_symbol_pos <= 1'b0;
		end else begin
			case (state_r)
				PCR_TP_IDLE: begin
					o_active <= 1'b0;
					o_symbol_pos <= 1'b0;
					if (i_start) begin
						// count is latched so a mid-burst write cannot shorten it
						state_r <= PCR_TP_SEND;
						left_r <= {i_len, 1'b0} + 7'h01;
						o_active <= 1'b1;
						o_symbol_pos <= 1'b1;
					end
				end
				PCR_TP_SEND: begin
					if (left_r == 7'h00) begin
						state_r <= PCR_TP_IDLE;
						o_active <= 1'b0;
						o_symbol_pos <= 1'b0;
					end else begin
						left_r <= left_r - 7'h01;
						o_symbol_pos <= ~o_symbol_pos;
					end
				end
				default: state_r <= PCR_TP_IDLE;
			endcase
		end
	end
endmodule : pcr_test_pattern
`default_nettype wire
